// file: common/sbs_pkg.sv
// Package for the system bus slave: widths, layout and timing constants.
// Assumes a 50 MHz core clock and an active-low backplane.
package sbs_pkg;
	localparam int SBS_ADDR_W = 24;
	localparam int SBS_IO_ADDR_W = 16;
	localparam int SBS_IO_SHORT_W = 8;
	localparam int SBS_DATA_W = 16;
	localparam int SBS_BYTE_W = 8;
	localparam int SBS_INT_W = 8;
	localparam int SBS_MEM_DEPTH_LOG2 = 8;
	localparam int SBS_CLK_PERIOD_NS = 20;
	localparam int SBS_ACK_RELEASE_NS = 65;
	// Longest time rounds down
	localparam int SBS_ACK_RELEASE_CYC = SBS_ACK_RELEASE_NS / SBS_CLK_PERIOD_NS;
	localparam logic [15:0] SBS_IO_BASE_RST = 16'h0040;
	localparam logic [23:0] SBS_MEM_BASE_RST = 24'h000000;
	localparam logic [7:0] SBS_VECTOR_RST = 8'h20;
	typedef enum logic [4:0] {
		SBS_IDLE = 5'h01,
		SBS_READ = 5'h02,
		SBS_WRITE = 5'h04,
		SBS_ACK = 5'h08,
		SBS_INTERRUPT_ACK = 5'h10
	} sbs_state_type;
endpackage

// file: hdl/sbs_sync.sv
// Three-stage synchroniser for a group of pins.
// Output changes only when stages two and three agree.
module sbs_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level_out);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			level_out <= INIT;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level_out <= next_level;
		end
	end
endmodule

// file: hdl/sbs_mem.sv
// Word memory of the slave, with byte write enables and registered read.
// Assumes one access per clock from the slave control.
module sbs_mem #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input wire logic clk_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [1:0] wr_en_in,
	input wire logic [DW-1:0] wr_data_in,
	output logic [DW-1:0] rd_data_out
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	always_ff @(posedge clk_in) begin
		if (wr_en_in[0]) begin
			mem[addr_in][DW/2-1:0] <= wr_data_in[DW/2-1:0];
		end
		if (wr_en_in[1]) begin
			mem[addr_in][DW-1:DW/2] <= wr_data_in[DW-1:DW/2];
		end
		rd_data_out <= mem[addr_in];
	end
endmodule

// file: hdl/sbs_slave.sv
// System bus slave: RAM or ROM window, I/O port, interrupt source.
// Assumes all bus pins are active low and arrive asynchronously; lines
// released by this module float high through backplane pull-ups.
// Behaviour
// - Active-low pins; released lines float high.
// - Contention logic follows bus clock, any speed; here the bus clock is only counted on busclk_edges_out.
// - Command means valid address; perform it.
// - Acknowledge only after data placed/taken.
// - System reset forces known state.
// - Twenty-four address lines for memory.
// - I/O uses lower sixteen address lines.
// - I/O decode selectable: 8 or 16 bits.
// - RAM override line silences RAM slaves.
// - ROM override line silences ROM slaves.
// - Upper byte enable selects data bits 8-F.
// - Sixteen data lines, line zero least significant.
// - Eight request lines, zero highest priority; here one request output only, INT_LINE unused.
// - Interrupt ack freezes status, vector on data.
// - Acknowledge released within 65ns of command removal; here up to four core clocks (80ns) later.
// - Word transfer: upper enable, address bit zero low.
module sbs_slave
	import sbs_pkg::*;
#(
	parameter int MEM_AW = SBS_MEM_DEPTH_LOG2,
	parameter int INT_LINE = 3
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic bus_clock_n_in,
	input wire logic init_n_in,
	input wire logic memory_read_cmd_n_in,
	input wire logic memory_write_cmd_n_in,
	input wire logic io_read_cmd_n_in,
	input wire logic io_write_cmd_n_in,
	input wire logic [SBS_ADDR_W-1:0] address_lines_n_in,
	input wire logic ram_override_n_in,
	input wire logic rom_override_n_in,
	input wire logic upper_byte_enable_n_in,
	input wire logic [SBS_DATA_W-1:0] data_lines_n_in,
	output logic [SBS_DATA_W-1:0] data_lines_n_out,
	output logic [SBS_DATA_W-1:0] data_lines_oe_out,
	output logic transfer_ack_n_out,
	output logic transfer_ack_oe_out,
	input wire logic interrupt_ack_n_in,
	output logic int_request_n_out,
	output logic int_request_oe_out,
	input wire logic cfg_io_full_decode_in,
	input wire logic cfg_is_rom_in,
	input wire logic [SBS_IO_ADDR_W-1:0] cfg_io_base_in,
	input wire logic [SBS_ADDR_W-1:0] cfg_mem_base_in,
	input wire logic [SBS_BYTE_W-1:0] cfg_vector_in,
	input wire logic irq_event_in,
	output logic irq_pending_out,
	output logic [SBS_DATA_W-1:0] io_port_out,
	output logic [SBS_INT_W-1:0] busclk_edges_out
);
	localparam int CTRL_W = 9;
	localparam logic [CTRL_W-1:0] CTRL_IDLE = 9'h1ff;

	logic [CTRL_W-1:0] ctrl_sync;
	logic [SBS_ADDR_W-1:0] addr_sync;
	logic [SBS_DATA_W-1:0] data_sync;
	logic bclk_sync;
	logic bclk_prev;
	sbs_state_type state;
	sbs_state_type next_state;
	logic [SBS_DATA_W-1:0] rd_hold;
	logic [SBS_DATA_W-1:0] io_port;
	logic [1:0] lane_hold;
	logic mem_sel_hold;
	logic [1:0] wait_cnt;
	logic [SBS_DATA_W-1:0] mem_rd_data;

	// Synchronise every incoming pin, active-low to active-high inside
	sbs_sync #(.WIDTH(CTRL_W), .INIT(CTRL_IDLE)) u_ctrl_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in({init_n_in, memory_read_cmd_n_in, memory_write_cmd_n_in,
			io_read_cmd_n_in, io_write_cmd_n_in, ram_override_n_in,
			rom_override_n_in, upper_byte_enable_n_in, interrupt_ack_n_in}),
		.level_out(ctrl_sync)
	);
	sbs_sync #(.WIDTH(SBS_ADDR_W), .INIT('1)) u_addr_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(address_lines_n_in),
		.level_out(addr_sync)
	);
	sbs_sync #(.WIDTH(SBS_DATA_W), .INIT('1)) u_data_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(data_lines_n_in),
		.level_out(data_sync)
	);
	sbs_sync #(.WIDTH(1), .INIT(1'b1)) u_bclk_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(bus_clock_n_in),
		.level_out(bclk_sync)
	);

	wire init_act = ~ctrl_sync[8];
	wire mrd = ~ctrl_sync[7];
	wire mwr = ~ctrl_sync[6];
	wire ird = ~ctrl_sync[5];
	wire iwr = ~ctrl_sync[4];
	wire inh_ram = ~ctrl_sync[3];
	wire inh_rom = ~ctrl_sync[2];
	wire bhe = ~ctrl_sync[1];
	wire interrupt_ack = ~ctrl_sync[0];
	wire [SBS_ADDR_W-1:0] addr = ~addr_sync;
	wire [SBS_DATA_W-1:0] wdata = ~data_sync;
	wire soft_rst = rst_in | init_act;
	wire any_cmd = mrd | mwr | ird | iwr;

	// Decode for the I/O space only; memory uses mem_hit
	function automatic logic io_match(input logic [SBS_ADDR_W-1:0] a,
		input logic [SBS_IO_ADDR_W-1:0] base, input logic full);
		logic lo_eq;
		logic hi_eq;
		lo_eq = a[SBS_IO_SHORT_W-1:0] == base[SBS_IO_SHORT_W-1:0];
		hi_eq = a[SBS_IO_ADDR_W-1:SBS_IO_SHORT_W]
			== base[SBS_IO_ADDR_W-1:SBS_IO_SHORT_W];
		// Upper bits ignored in short mode; masters may drive junk there
		io_match = lo_eq & (hi_eq | ~full);
	endfunction

	wire mem_hit = addr[SBS_ADDR_W-1:MEM_AW+1] == cfg_mem_base_in[SBS_ADDR_W-1:MEM_AW+1];
	wire inhibited = cfg_is_rom_in ? inh_rom : inh_ram;
	wire mem_sel = (mrd | mwr) & mem_hit & ~inhibited;
	wire io_sel = (ird | iwr) & io_match(addr, cfg_io_base_in, cfg_io_full_decode_in);
	wire sel_rd = (mrd & mem_sel) | (ird & io_sel);
	wire sel_wr = (mwr & mem_sel & ~cfg_is_rom_in) | (iwr & io_sel);
	wire sel_rom_wr = mwr & mem_sel & cfg_is_rom_in;
	// Byte lanes: bit0 low lane, bit1 high lane
	wire word_xfer = bhe & ~addr[0];
	wire odd_high = bhe & addr[0];
	wire [1:0] lanes = word_xfer ? 2'h3 : (odd_high ? 2'h2 : 2'h1);
	// Odd byte without upper enable arrives on the low lane and is written to the high lane
	wire swap = ~bhe & addr[0];
	wire [SBS_DATA_W-1:0] wdata_aligned = swap ? {wdata[SBS_BYTE_W-1:0],
		wdata[SBS_BYTE_W-1:0]} : wdata;
	wire [1:0] wr_lanes = swap ? 2'h2 : lanes;

	wire [MEM_AW-1:0] mem_addr = addr[MEM_AW:1];
	wire [1:0] mem_we = (state == SBS_IDLE && mwr && mem_sel && !cfg_is_rom_in)
		? wr_lanes : 2'h0;

	sbs_mem #(.AW(MEM_AW), .DW(SBS_DATA_W)) u_mem (
		.clk_in(clk_in),
		.addr_in(mem_addr),
		.wr_en_in(mem_we),
		.wr_data_in(wdata_aligned),
		.rd_data_out(mem_rd_data)
	);

	// Bus clock edge count; no free-running assumption, edges may stop
	wire bclk_rise = bclk_sync & ~bclk_prev;

	// Interrupt source; a new event beats a same-cycle acknowledge clear
	logic irq_pend;
	logic interrupt_ack_prev;
	// Vector register loads in the first INTERRUPT_ACK cycle; ack waits one more
	logic vec_loaded;
	wire interrupt_ack_rise = interrupt_ack & ~interrupt_ack_prev;
	wire next_irq = irq_event_in | (irq_pend & ~interrupt_ack_rise);

	always_comb begin
		next_state = state;
		case (state)
			SBS_IDLE: begin
				if (interrupt_ack && irq_pend) begin
					next_state = SBS_INTERRUPT_ACK;
				end else if (sel_rd) begin
					next_state = SBS_READ;
				end else if (sel_wr || sel_rom_wr) begin
					next_state = SBS_WRITE;
				end
			end
			SBS_READ: next_state = SBS_ACK;
			SBS_WRITE: next_state = SBS_ACK;
			SBS_INTERRUPT_ACK: next_state = interrupt_ack ? SBS_INTERRUPT_ACK : SBS_IDLE;
			SBS_ACK: next_state = any_cmd ? SBS_ACK : SBS_IDLE;
			default: next_state = SBS_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (soft_rst) begin
			state <= SBS_IDLE;
			mem_sel_hold <= 1'b0;
			lane_hold <= 2'h0;
		end else begin
			state <= next_state;
			if (state == SBS_IDLE) begin
				mem_sel_hold <= mrd;
				lane_hold <= lanes;
			end
		end
	end

	// Read data stage: memory word registers one cycle after selection
	wire [SBS_DATA_W-1:0] rd_src = mem_sel_hold ? mem_rd_data : io_port;
	wire [SBS_DATA_W-1:0] rd_swapped = (~lane_hold[1] & ~lane_hold[0]) ? rd_src
		: rd_src;
	wire swap_rd = (lane_hold == 2'h1) & addr[0];
	wire [SBS_DATA_W-1:0] rd_aligned = swap_rd ? {rd_swapped[SBS_DATA_W-1:SBS_BYTE_W],
		rd_swapped[SBS_DATA_W-1:SBS_BYTE_W]} : rd_swapped;

	always_ff @(posedge clk_in) begin
		if (soft_rst) begin
			rd_hold <= '0;
			io_port <= '0;
			wait_cnt <= 2'h0;
		end else begin
			if (state == SBS_READ) begin
				rd_hold <= rd_aligned;
			end else if (state == SBS_INTERRUPT_ACK) begin
				rd_hold <= {{SBS_BYTE_W{1'b0}}, cfg_vector_in};
			end
			if (state == SBS_IDLE && iwr && io_sel) begin
				if (wr_lanes[0]) begin
					io_port[SBS_BYTE_W-1:0] <= wdata_aligned[SBS_BYTE_W-1:0];
				end
				if (wr_lanes[1]) begin
					io_port[SBS_DATA_W-1:SBS_BYTE_W] <= wdata_aligned[SBS_DATA_W-1:SBS_BYTE_W];
				end
			end
			wait_cnt <= (state == SBS_ACK && !any_cmd) ? wait_cnt + 2'h1 : 2'h0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (soft_rst) begin
			irq_pend <= 1'b0;
			interrupt_ack_prev <= 1'b0;
			vec_loaded <= 1'b0;
			bclk_prev <= 1'b1;
			busclk_edges_out <= '0;
		end else begin
			irq_pend <= next_irq;
			interrupt_ack_prev <= interrupt_ack;
			vec_loaded <= state == SBS_INTERRUPT_ACK;
			bclk_prev <= bclk_sync;
			busclk_edges_out <= busclk_edges_out + {{(SBS_INT_W-1){1'b0}}, bclk_rise};
		end
	end

	// Acknowledge only once data is on the lines or taken
	wire vec_ack = state == SBS_INTERRUPT_ACK && vec_loaded && interrupt_ack;
	wire ack_act = (state == SBS_ACK && any_cmd) || vec_ack;
	wire drive_data = (state == SBS_ACK && mem_sel_hold | (lane_hold != 2'h0))
		&& (mrd || ird) || vec_ack;
	wire [1:0] drive_lanes = state == SBS_INTERRUPT_ACK ? 2'h1 : lane_hold;

	// Drive low when asserted, release otherwise for the pull-up
	assign transfer_ack_n_out = 1'b0;
	assign transfer_ack_oe_out = ack_act;
	assign data_lines_n_out = ~rd_hold;
	// Swapped odd byte travels on the low lane only
	assign data_lines_oe_out = drive_data ? {{SBS_BYTE_W{drive_lanes[1]}},
		{SBS_BYTE_W{drive_lanes[0]}}} : '0;
	// Single request output, INT_LINE unused; lower line number means higher priority
	assign int_request_n_out = 1'b0;
	assign int_request_oe_out = irq_pend;
	assign irq_pending_out = irq_pend;
	assign io_port_out = io_port;
endmodule

// file: dv/sbs_checker.sv
// Port assertions for the bus slave, single clock domain.
// Bound into every sbs_slave instance; bus pins are active low.
module sbs_checker
	import sbs_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic memory_read_cmd_n_in,
	input wire logic memory_write_cmd_n_in,
	input wire logic io_read_cmd_n_in,
	input wire logic io_write_cmd_n_in,
	input wire logic interrupt_ack_n_in,
	input wire logic [SBS_ADDR_W-1:0] address_lines_n_in,
	input wire logic ram_override_n_in,
	input wire logic rom_override_n_in,
	input wire logic upper_byte_enable_n_in,
	input wire logic cfg_is_rom_in,
	input wire logic irq_event_in,
	input wire logic [SBS_DATA_W-1:0] data_lines_oe_out,
	input wire logic transfer_ack_oe_out,
	input wire logic transfer_ack_n_out,
	input wire logic int_request_n_out,
	input wire logic int_request_oe_out,
	input wire logic irq_pending_out
);
	wire io_off = io_read_cmd_n_in & io_write_cmd_n_in & interrupt_ack_n_in;
	wire cmd_off = io_off & memory_read_cmd_n_in & memory_write_cmd_n_in;
	// Odd byte without upper enable is swapped onto the low lane
	wire [15:0] lanes = upper_byte_enable_n_in ? 16'h00ff
		: (address_lines_n_in[0] ? 16'hffff : 16'hff00);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_ack_has_cmd: assert property ($rose(transfer_ack_oe_out) |-> !$past(cmd_off, 3))
		else $error("ack without held command");
	a_ack_release: assert property ($rose(cmd_off) |-> ##[1:5] !transfer_ack_oe_out)
		else $error("ack held too long");
	a_read_lanes: assert property (transfer_ack_oe_out && !memory_read_cmd_n_in
		|-> data_lines_oe_out == lanes) else $error("wrong read lanes");
	a_write_quiet: assert property (!(memory_write_cmd_n_in & io_write_cmd_n_in)
		|-> data_lines_oe_out == 16'h0000) else $error("data driven in write");
	a_data_with_ack: assert property (data_lines_oe_out != 16'h0000 |-> transfer_ack_oe_out)
		else $error("data driven without ack");
	a_ram_inhibit: assert property (!ram_override_n_in && !cfg_is_rom_in && io_off
		|-> !transfer_ack_oe_out) else $error("RAM answered under override");
	a_rom_inhibit: assert property (!rom_override_n_in && cfg_is_rom_in && io_off
		|-> !transfer_ack_oe_out) else $error("ROM answered under override");
	a_reset_quiet: assert property (disable iff (1'b0) rst_in
		|=> !transfer_ack_oe_out && !irq_pending_out) else $error("active after reset");
	a_irq_source: assert property ($rose(irq_pending_out) |-> $past(irq_event_in))
		else $error("pending without event");
	a_ack_drives_low: assert property (transfer_ack_oe_out |-> !transfer_ack_n_out)
		else $error("ack driven high");
	a_irq_drives_low: assert property (int_request_oe_out |-> !int_request_n_out)
		else $error("request driven high");
endmodule
bind sbs_slave sbs_checker chk_u (.*);

// file: dv/sbs_master_model.sv
// Bus master model: one transfer at a time, pins active low.
// Released lines read high, as through the backplane pull-ups.
module sbs_master_model
	import sbs_pkg::*;
(
	input wire logic clk_in,
	input wire logic ack_oe_in,
	input wire logic [SBS_DATA_W-1:0] slv_data_n_in,
	input wire logic [SBS_DATA_W-1:0] slv_oe_in,
	output logic [4:0] cmd_n_out,
	output logic [SBS_ADDR_W-1:0] addr_n_out,
	output logic bhe_n_out,
	output logic [SBS_DATA_W-1:0] data_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [SBS_DATA_W-1:0] drv_n = '1;
	logic drv_on = 1'b0;
	assign data_n_out = (slv_oe_in & slv_data_n_in) | (~slv_oe_in & (drv_on ? drv_n : '1));
	// Sole master: owns the bus, no lock or arbitration needed
	initial begin
		cmd_n_out = '1;
		addr_n_out = '1;
		bhe_n_out = 1'b1;
	end
	// k: 0 mem read, 1 mem write, 2 io read, 3 io write, 4 int ack
	task automatic xfer(input int k, input logic [23:0] a, input logic bhe,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		int i;
		ok = 1'b0;
		rd = '1;
		addr_n_out = ~a;
		bhe_n_out = ~bhe;
		drv_n = ~wd;
		drv_on = (k == 1 || k == 3);
		repeat (3) @(posedge clk_in);
		#1 cmd_n_out[k] = 1'b0;
		for (i = 0; i < 30 && !ok; i++) begin
			@(posedge clk_in);
			if (ack_oe_in === 1'b1) begin
				ok = 1'b1;
				rd = ~data_n_out;
			end
		end
		#1 cmd_n_out = '1;
		drv_on = 1'b0;
		for (i = 0; i < 10 && ack_oe_in !== 1'b0; i++) @(posedge clk_in);
		repeat (3) @(posedge clk_in);
		#1 addr_n_out = '1;
		bhe_n_out = 1'b1;
		@(posedge clk_in);
		#1;
	endtask
endmodule

// file: dv/tb_top.sv
// Bench for the bus slave: random and corner transfers via the master model.
// Pins change 1 ns after the rising clock edge, except the bus clock.
module tb_top
	import sbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, rst = 1, bclk_n = 1, brun = 0, rovr = 0, povr = 0;
	logic full = 0, rom = 0, irq = 0, init_n = 1, ok, b, bhe_n, pend, ack, iro;
	logic [4:0] cmd_n;
	logic [23:0] a, adr_n;
	logic [7:0] vec, bc, bco;
	logic [15:0] rd, wd, pexp, din_n, dout_n, doe, port, mref[256];
	int n_fail = 0, num_checks = 0, seed = 88836, i;
	initial forever #10 clk_in = ~clk_in;
	initial begin
		#7;
		forever #80 if (brun) bclk_n = ~bclk_n;
	end
	sbs_slave dut_u (.clk_in(clk_in), .rst_in(rst), .bus_clock_n_in(bclk_n), .init_n_in(init_n),
		.memory_read_cmd_n_in(cmd_n[0]), .memory_write_cmd_n_in(cmd_n[1]),
		.io_read_cmd_n_in(cmd_n[2]), .io_write_cmd_n_in(cmd_n[3]), .address_lines_n_in(adr_n),
		.ram_override_n_in(~rovr), .rom_override_n_in(~povr), .upper_byte_enable_n_in(bhe_n),
		.data_lines_n_in(din_n), .data_lines_n_out(dout_n), .data_lines_oe_out(doe),
		.transfer_ack_n_out(), .transfer_ack_oe_out(ack), .interrupt_ack_n_in(cmd_n[4]),
		.int_request_n_out(), .int_request_oe_out(iro), .cfg_io_full_decode_in(full),
		.cfg_is_rom_in(rom), .cfg_io_base_in(16'h0040), .cfg_mem_base_in(24'h000000),
		.cfg_vector_in(vec), .irq_event_in(irq), .irq_pending_out(pend),
		.io_port_out(port), .busclk_edges_out(bco));
	sbs_master_model mst_u (.clk_in(clk_in), .ack_oe_in(ack), .slv_data_n_in(dout_n),
		.slv_oe_in(doe), .cmd_n_out(cmd_n), .addr_n_out(adr_n), .bhe_n_out(bhe_n),
		.data_n_out(din_n));
	task finish_test();
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, s);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// A missing ack that was due ends the run: later checks would only cascade
	task automatic go(input int k, input logic [23:0] ad, input logic bhe, input logic e);
		mst_u.xfer(k, ad, bhe, wd, rd, ok);
		chk("ack", {15'h0, e}, {15'h0, ok});
		if (e && ok !== 1'b1) finish_test();
	endtask
	function automatic logic [15:0] merge(logic [15:0] o, w, logic bhe, a0);
		case ({bhe, a0})
			2'b10: merge = w;
			2'b00: merge = {o[15:8], w[7:0]};
			2'b01: merge = {w[7:0], o[7:0]};
			default: merge = {w[15:8], o[7:0]};
		endcase
	endfunction
	initial begin
		vec = 8'($random(seed));
		idle(20);
		rst = 0;
		idle(4);
		for (i = 0; i < 256; i++) begin
			wd = 16'($random(seed));
			mref[i] = wd;
			go(1, {15'h0, i[7:0], 1'b0}, 1, 1);
		end
		for (i = 0; i < 40; i++) begin
			a = {15'h0, 9'($random(seed))};
			wd = 16'($random(seed));
			b = 1'($random(seed));
			mref[a[8:1]] = merge(mref[a[8:1]], wd, b, a[0]);
			go(1, a, b, 1);
			go(0, {a[23:1], 1'b0}, 1, 1);
			chk("mem", mref[a[8:1]], rd);
		end
		go(0, 24'h000200, 1, 0);
		rovr = 1;
		idle(6);
		go(0, 24'h000010, 1, 0);
		rom = 1;
		idle(6);
		go(0, 24'h000010, 1, 1);
		wd = ~mref[8];
		go(1, 24'h000010, 1, 1);
		rovr = 0;
		povr = 1;
		idle(6);
		go(0, 24'h000010, 1, 0);
		povr = 0;
		rom = 0;
		idle(6);
		go(0, 24'h000010, 1, 1);
		chk("rom_write", mref[8], rd);
		pexp = 16'h0000;
		for (i = 0; i < 2; i++) begin
			full = i[0];
			idle(6);
			wd = 16'($random(seed));
			go(3, {8'($random(seed)), 16'h1240}, 1, !full);
			if (!full) pexp = wd;
			chk("port", pexp, port);
			wd = 16'($random(seed));
			pexp = wd;
			go(3, {8'($random(seed)), 16'h0040}, 1, 1);
			go(2, 24'h000040, 1, 1);
			chk("io_read", pexp, rd);
		end
		init_n = 0;
		idle(6);
		init_n = 1;
		idle(6);
		chk("init_port", 16'h0000, port);
		go(4, 24'h0, 0, 0);
		irq = 1;
		idle(1);
		irq = 0;
		idle(2);
		chk("request", 16'h1, {15'h0, iro});
		go(4, 24'h0, 0, 1);
		chk("vector", {8'h0, vec}, {8'h0, rd[7:0]});
		chk("pending", 16'h0, {15'h0, pend});
		bc = bco;
		brun = 1;
		idle(60);
		brun = 0;
		chk("bclk_run", 16'h1, {15'h0, bco !== bc});
		idle(20);
		bc = bco;
		idle(40);
		chk("bclk_stop", {8'h0, bc}, {8'h0, bco});
		finish_test();
	end
endmodule
